/* File: inc/ctx_pkg.sv */
/*
 * package for the continuous transmit test block: register offsets, field
 * layouts, reset values, command codes and state enumerations.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
package ctx_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_STATE_CMD   = 8'h08; // state_command_field
	localparam logic [7:0] ADDR_CHANNEL_CFG = 8'h20; // channel_config_register
	localparam logic [7:0] ADDR_TEST_CFG    = 8'h3c; // mode and tone selection
	localparam logic [7:0] ADDR_FRAME_LEN   = 8'h40; // frame length field
	localparam logic [7:0] ADDR_FRAME_DATA  = 8'h44; // psdu octet write port
	localparam logic [7:0] ADDR_STATUS      = 8'h48; // transceiver_state_field

	// ---------------------------------------------------------------
	// commands and state codes
	// ---------------------------------------------------------------
	localparam logic [4:0] CMD_NOP      = 5'h00;
	localparam logic [4:0] CMD_TX_START = 5'h02;
	localparam logic [4:0] CMD_FORCE_OFF = 5'h03;
	localparam logic [4:0] CMD_PLL_ON   = 5'h09;
	localparam logic [4:0] CMD_OFF      = 5'h08;

	localparam logic [4:0] STS_OFF      = 5'h08;
	localparam logic [4:0] STS_PLL_ON   = 5'h09;
	localparam logic [4:0] STS_BUSY_TX  = 5'h02;

	// ---------------------------------------------------------------
	// test configuration fields and reset values
	// ---------------------------------------------------------------
	localparam int        TCFG_MODE_BIT = 0;   // 0 prbs, 1 cw
	localparam int        TCFG_TONE_LSB = 1;   // two-bit tone select
	localparam logic [3:0] CHANNEL_RST  = 4'hb;
	localparam logic [2:0] TCFG_RST     = 3'h0;
	localparam logic [6:0] LEN_RST      = 7'h00;

	// tone codes; offset in units of 0.5 mhz, signed
	localparam logic [1:0] TONE_M2P0 = 2'h0;
	localparam logic [1:0] TONE_P0P5 = 2'h1;
	localparam logic [1:0] TONE_M0P5 = 2'h2;
	localparam logic signed [3:0] OFS_M2P0 = -4'sd4;
	localparam logic signed [3:0] OFS_P0P5 = 4'sd1;
	localparam logic signed [3:0] OFS_M0P5 = -4'sd1;

	typedef enum logic [1:0] {
		RADIO_OFF,
		RADIO_PLL,
		RADIO_TX
	} radio_state_t;

endpackage : ctx_pkg

/* File: hw/ctx_sync.sv */
/*
 * three-stage synchroniser for the test-enable pin.
 * assumes the pin is asynchronous to clk_in; output changes once
 * stages two and three agree.
 */
`timescale 1ns/1ns
`default_nettype none

module ctx_sync (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// pin and filtered level
	input  wire logic pin_in,
	output var  logic level_out
);

	logic [2:0] stage_r;
	logic [2:0] stage_nxt;
	logic       level_r;
	logic       level_nxt;

	// ---------------------------------------------------------------
	// next values
	// ---------------------------------------------------------------
	// first stage feeds only the second; agreement filters a glitch
	always_comb begin
		stage_nxt = {stage_r[1:0], pin_in};
		level_nxt = level_r;
		if (stage_r[1] == stage_r[2]) begin
			level_nxt = stage_r[2];
		end
	end

	// registers; pulled down level after reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			stage_r <= 3'h0;
			level_r <= 1'b0;
		end else begin
			stage_r <= stage_nxt;
			level_r <= level_nxt;
		end
	end

	assign level_out = level_r;

endmodule : ctx_sync
`default_nettype wire

/* File: hw/ctx_top.sv */
/*
 * continuous transmit test mode: apb registers, psdu store and the
 * stream / tone generator that feeds the modulator.
 * assumes the host keeps the programming order and the pin low in
 * normal use; one 250 mhz clock, synchronous reset.
 */
// What this block does
// - prbs repeats buffered psdu only, endlessly
// - prbs centred on programmed channel
// - cw offers minus2, plus0.5, minus0.5 mhz
// - no cw tone at channel centre
// - test mode only while pin high
// - transmission starts after pll then tx_start
`timescale 1ns/1ns
`default_nettype none

module ctx_top
	import ctx_pkg::*;
#(
	parameter int DEPTH = 128
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	// apb slave
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output var  logic [31:0]       prdata_out,
	output var  logic              pready_out,
	output var  logic              pslverr_out,
	// test-enable pin
	input  wire logic              test_enable_pin_in,
	// modulator side
	output var  logic              tx_active_out,
	output var  logic              tx_cw_out,
	output var  logic [7:0]        tx_octet_out,
	output var  logic              tx_octet_valid_out,
	input  wire logic              tx_octet_ready_in,
	output var  logic [3:0]        tx_channel_out,
	output var  logic signed [3:0] tx_offset_out
);

	logic test_en;

	// ---------------------------------------------------------------
	// pin synchroniser
	// ---------------------------------------------------------------
	ctx_sync u_sync (
		.clk_in   (clk_in),
		.srst_in  (srst_in),
		.pin_in   (test_enable_pin_in),
		.level_out(test_en)
	);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0]         mem [DEPTH];
	radio_state_t       state_r, state_nxt;
	logic [3:0]         chan_r, chan_nxt;
	logic [2:0]         tcfg_r, tcfg_nxt;
	logic [6:0]         len_r, len_nxt;
	logic [6:0]         wptr_r, wptr_nxt;
	logic [6:0]         rptr_r, rptr_nxt;
	logic               cw_r, cw_nxt;
	logic [1:0]         tone_r, tone_nxt;
	logic [31:0]        prdata_r, prdata_nxt;
	logic               pready_r, pready_nxt;
	logic               pslverr_r, pslverr_nxt;
	logic               oct_vld_r, oct_vld_nxt;
	logic [7:0]         octet_r, octet_nxt;
	logic signed [3:0]  ofs_r, ofs_nxt;
	logic               mem_we;
	logic               acc;
	logic               wr;
	logic [4:0]         cmd;

	// tone code to offset; code 3 would be the centre, so it falls back
	function automatic logic signed [3:0] tone_ofs(input logic [1:0] code);
		unique case (code)
			TONE_P0P5: tone_ofs = OFS_P0P5;
			TONE_M0P5: tone_ofs = OFS_M0P5;
			default:   tone_ofs = OFS_M2P0;
		endcase
	endfunction : tone_ofs

	// address decode helper
	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == ADDR_STATE_CMD) || (a == ADDR_CHANNEL_CFG) ||
			(a == ADDR_TEST_CFG) || (a == ADDR_FRAME_LEN) ||
			(a == ADDR_FRAME_DATA) || (a == ADDR_STATUS);
	endfunction : known_addr

	assign acc = psel_in && penable_in && !pready_r;
	assign wr  = acc && pwrite_in;
	assign cmd = pwdata_in[4:0];
	assign mem_we = wr && (paddr_in == ADDR_FRAME_DATA) && (state_r != RADIO_TX);

	// ---------------------------------------------------------------
	// register bus and radio state
	// ---------------------------------------------------------------
	// one wait state: pready rises in the cycle after the access begins
	always_comb begin
		state_nxt   = state_r;
		chan_nxt    = chan_r;
		tcfg_nxt    = tcfg_r;
		len_nxt     = len_r;
		wptr_nxt    = wptr_r;
		cw_nxt      = cw_r;
		tone_nxt    = tone_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = acc;
		pslverr_nxt = acc && !known_addr(paddr_in);
		if (wr) begin
			unique case (paddr_in)
				ADDR_CHANNEL_CFG: chan_nxt = pwdata_in[3:0];
				ADDR_TEST_CFG:    tcfg_nxt = pwdata_in[2:0];
				ADDR_FRAME_LEN: begin
					len_nxt  = pwdata_in[6:0];
					wptr_nxt = 7'h00; // new frame restarts the download
				end
				ADDR_FRAME_DATA:  wptr_nxt = (state_r != RADIO_TX) ? wptr_r + 7'h01 : wptr_r;
				ADDR_STATE_CMD: begin
					if (cmd == CMD_OFF || cmd == CMD_FORCE_OFF) begin
						state_nxt = RADIO_OFF;
					end else if (cmd == CMD_PLL_ON && state_r == RADIO_OFF) begin
						state_nxt = RADIO_PLL;
					end else if (cmd == CMD_TX_START && state_r == RADIO_PLL && test_en) begin
						state_nxt = RADIO_TX;
						cw_nxt    = tcfg_r[TCFG_MODE_BIT];
						tone_nxt  = tcfg_r[TCFG_TONE_LSB +: 2];
					end
				end
				default: ;
			endcase
		end
		// synchronised pin low (test_en) ends the test at the next edge
		if (!test_en && state_r == RADIO_TX) begin
			state_nxt = RADIO_PLL;
		end
		if (acc && !pwrite_in) begin
			unique case (paddr_in)
				ADDR_STATE_CMD:   prdata_nxt = 32'h0;
				ADDR_CHANNEL_CFG: prdata_nxt = {28'h0, chan_r};
				ADDR_TEST_CFG:    prdata_nxt = {29'h0, tcfg_r};
				ADDR_FRAME_LEN:   prdata_nxt = {25'h0, len_r};
				ADDR_STATUS: begin
					unique case (state_r)
						RADIO_OFF: prdata_nxt = {27'h0, STS_OFF};
						RADIO_PLL: prdata_nxt = {27'h0, STS_PLL_ON};
						default:   prdata_nxt = {27'h0, STS_BUSY_TX};
					endcase
				end
				default:          prdata_nxt = 32'h0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// stream and tone generator
	// ---------------------------------------------------------------
	// psdu only, from octet 0, wrapping at the frame length
	always_comb begin
		rptr_nxt    = rptr_r;
		oct_vld_nxt = 1'b0;
		octet_nxt   = octet_r;
		// offset follows the next state, so it lines up with tx_active
		ofs_nxt     = (state_nxt == RADIO_TX && cw_nxt) ? tone_ofs(tone_nxt) : 4'sd0;
		if (state_r == RADIO_TX && test_en) begin
			if (cw_r) begin
				oct_vld_nxt = 1'b0; // tone carries no octets
			end else begin
				oct_vld_nxt = 1'b1;
				if (!oct_vld_r || tx_octet_ready_in) begin
					octet_nxt = mem[rptr_r];
					rptr_nxt  = (rptr_r + 7'h01 >= len_r) ? 7'h00 : rptr_r + 7'h01;
				end
			end
		end else begin
			rptr_nxt = 7'h00;
		end
	end

	// frame store; written only outside transmission
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[wptr_r] <= pwdata_in[7:0];
		end
	end

	// registers
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_r   <= RADIO_OFF;
			chan_r    <= CHANNEL_RST;
			tcfg_r    <= TCFG_RST;
			len_r     <= LEN_RST;
			wptr_r    <= 7'h00;
			rptr_r    <= 7'h00;
			cw_r      <= 1'b0;
			tone_r    <= TONE_M2P0;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			oct_vld_r <= 1'b0;
			octet_r   <= 8'h00;
			ofs_r     <= 4'sd0;
		end else begin
			state_r   <= state_nxt;
			chan_r    <= chan_nxt;
			tcfg_r    <= tcfg_nxt;
			len_r     <= len_nxt;
			wptr_r    <= wptr_nxt;
			rptr_r    <= rptr_nxt;
			cw_r      <= cw_nxt;
			tone_r    <= tone_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			oct_vld_r <= oct_vld_nxt;
			octet_r   <= octet_nxt;
			ofs_r     <= ofs_nxt;
		end
	end

	// outputs straight from flops except tx_active, decoded from state_r; channel is a register too
	assign prdata_out         = prdata_r;
	assign pready_out         = pready_r;
	assign pslverr_out        = pslverr_r;
	assign tx_active_out      = (state_r == RADIO_TX);
	assign tx_cw_out          = cw_r;
	assign tx_octet_out       = octet_r;
	assign tx_octet_valid_out = oct_vld_r;
	assign tx_channel_out     = chan_r;
	assign tx_offset_out      = ofs_r;

endmodule : ctx_top
`default_nettype wire

/* File: verification/ctx_top_properties.sv */
/* checker for ctx_top: start, tone, stream and pin relations.
   assumes binding to ctx_top, one clock domain, ctx_pkg compiled first. */
`timescale 1ns/1ns
`default_nettype none
module ctx_top_properties
	import ctx_pkg::*;
(
	// clock and reset
	input wire logic              clk_in,
	input wire logic              srst_in,
	// apb
	input wire logic              psel_in,
	input wire logic              penable_in,
	input wire logic              pwrite_in,
	input wire logic [7:0]        paddr_in,
	input wire logic [31:0]       pwdata_in,
	input wire logic              pready_out,
	// pin and modulator side
	input wire logic              test_enable_pin_in,
	input wire logic              tx_active_out,
	input wire logic              tx_cw_out,
	input wire logic [7:0]        tx_octet_out,
	input wire logic              tx_octet_valid_out,
	input wire logic              tx_octet_ready_in,
	input wire logic [3:0]        tx_channel_out,
	input wire logic signed [3:0] tx_offset_out
);
	logic       acc_w;
	logic       start_w;
	logic       ch_wr_w;
	logic [3:0] ch_val_r;
	// completing writes, decoded from the bus alone
	assign acc_w = psel_in && penable_in && pwrite_in && pready_out;
	assign start_w = acc_w && paddr_in == ADDR_STATE_CMD && pwdata_in[4:0] == CMD_TX_START;
	assign ch_wr_w = acc_w && paddr_in == ADDR_CHANNEL_CFG;
	// last channel written, to judge the output against
	always_ff @(posedge clk_in) begin
		if (ch_wr_w) ch_val_r <= pwdata_in[3:0];
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence s_running;
		tx_active_out [*2];
	endsequence
	a_start_needs_cmd: assert property ($rose(tx_active_out) |->
		start_w || $past(start_w, 1) || $past(start_w, 2)) else $error("tx began without start");
	a_cw_tone_set: assert property (tx_active_out && tx_cw_out |->
		tx_offset_out == OFS_M2P0 || tx_offset_out == OFS_P0P5 || tx_offset_out == OFS_M0P5) else $error("bad tone");
	a_cw_off_centre: assert property (tx_active_out && tx_cw_out |-> tx_offset_out != 4'sd0)
		else $error("tone on centre");
	a_prbs_centre: assert property (tx_active_out && !tx_cw_out |-> tx_offset_out == 4'sd0)
		else $error("stream off centre");
	a_mode_held: assert property (s_running |-> $stable(tx_cw_out) && $stable(tx_offset_out))
		else $error("mode changed mid run");
	a_pin_drop_stop: assert property ($fell(test_enable_pin_in) |-> ##[1:8] !tx_active_out)
		else $error("tx outlived pin");
	a_octet_held: assert property (tx_octet_valid_out && !tx_octet_ready_in && tx_active_out |=>
		!tx_active_out || (tx_octet_valid_out && $stable(tx_octet_out))) else $error("octet dropped");
	a_channel_follows: assert property (ch_wr_w |-> ##[1:2] tx_channel_out == ch_val_r)
		else $error("channel not applied");
endmodule : ctx_top_properties
bind ctx_top ctx_top_properties chk (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pready_out(pready_out), .test_enable_pin_in(test_enable_pin_in), .tx_active_out(tx_active_out),
	.tx_cw_out(tx_cw_out), .tx_octet_out(tx_octet_out), .tx_octet_valid_out(tx_octet_valid_out),
	.tx_octet_ready_in(tx_octet_ready_in), .tx_channel_out(tx_channel_out), .tx_offset_out(tx_offset_out));
`default_nettype wire

/* File: verification/ctx_sink_model.sv */
/* modulator model: takes octets at full rate or one in three.
   assumes it shares clk_in and srst_in with the block. */
`timescale 1ns/1ns
`default_nettype none
module ctx_sink_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic slow_in,
	output var logic ready_out
);
	logic [1:0] cnt_r;
	// slow mode mimics a busy modulator, so held octets get exercised
	always_ff @(posedge clk_in) begin
		if (srst_in || cnt_r == 2'h2) cnt_r <= 2'h0;
		else cnt_r <= cnt_r + 2'h1;
	end
	assign ready_out = !slow_in || cnt_r == 2'h2;
endmodule : ctx_sink_model
`default_nettype wire

/* File: verification/continuous_tx_test_mode_test.sv */
/* self-checking bench for ctx_top over apb, with a modulator model.
   assumes ctx_pkg, ctx_sync, ctx_top and the checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t %s", $time, m); end end
module continuous_tx_test_mode_test;
	import ctx_pkg::*;
	logic clk_in, srst_in, psel_in, penable_in, pwrite_in, pin, slow, ready, err;
	logic tx_active, tx_cw, valid, pready_out, pslverr_out;
	logic [7:0] paddr_in, octet;
	logic [3:0] chan;
	logic signed [3:0] ofs;
	logic [31:0] pwdata_in, prdata_out, rd;
	int n_fail = 0;
	int comparisons = 0;
	ctx_top dut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .test_enable_pin_in(pin),
		.tx_active_out(tx_active), .tx_cw_out(tx_cw), .tx_octet_out(octet), .tx_octet_valid_out(valid),
		.tx_octet_ready_in(ready), .tx_channel_out(chan), .tx_offset_out(ofs));
	ctx_sink_model sink (.clk_in(clk_in), .srst_in(srst_in), .slow_in(slow), .ready_out(ready));
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// one apb transfer; waits for pready, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		psel_in <= 1'b1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
		@(posedge clk_in); penable_in <= 1'b1;
		// look between edges, where the registered answer has settled
		do begin
			@(negedge clk_in);
			t++;
		end while (pready_out !== 1'b1 && t < 50);
		rd = prdata_out;
		err = pslverr_out;
		if (t >= 50) n_fail++;
		@(posedge clk_in);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask : apb
	task automatic t_reset;
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd[4:0], STS_OFF, "reset state")
		`CHK(chan, CHANNEL_RST, "reset channel")
		apb(1'b0, 8'h7c, 32'h0);
		`CHK(err, 1'b1, "unmapped read")
		// start with the pin low must not transmit
		apb(1'b1, ADDR_STATE_CMD, CMD_PLL_ON);
		apb(1'b1, ADDR_STATE_CMD, CMD_TX_START);
		repeat (4) @(posedge clk_in);
		`CHK(tx_active, 1'b0, "start without pin")
		apb(1'b1, ADDR_STATE_CMD, CMD_OFF);
		$display("test reset done");
	endtask : t_reset
	task automatic t_prbs;
		logic [7:0] pat [3];
		int k, t;
		pat = '{8'ha1, 8'hb2, 8'hc3};
		k = 0; t = 0;
		apb(1'b1, ADDR_CHANNEL_CFG, 32'h5);
		apb(1'b1, ADDR_FRAME_LEN, 32'h3);
		for (int i = 0; i < 3; i++) apb(1'b1, ADDR_FRAME_DATA, {24'h0, pat[i]});
		apb(1'b1, ADDR_TEST_CFG, 32'h0);
		pin <= 1'b1;
		apb(1'b1, ADDR_STATE_CMD, CMD_TX_START);
		repeat (4) @(posedge clk_in);
		`CHK(tx_active, 1'b0, "start before pll")
		apb(1'b1, ADDR_STATE_CMD, CMD_PLL_ON);
		slow <= 1'b1;
		// watch from the start command on, so the first octet is seen too
		fork
			apb(1'b1, ADDR_STATE_CMD, CMD_TX_START);
			// seven octets wrap past the three loaded: no header, order kept
			while (k < 7 && t < 200) begin
				@(negedge clk_in); t++;
				if (valid === 1'b1 && ready === 1'b1) begin `CHK(octet, pat[k % 3], "octet order") k++; end
			end
		join
		`CHK(k, 7, "octet count")
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd[4:0], STS_BUSY_TX, "busy after start")
		`CHK(chan, 4'h5, "stream channel")
		`CHK(ofs, 4'sd0, "stream offset")
		@(posedge clk_in); slow <= 1'b0; pin <= 1'b0;
		repeat (8) @(posedge clk_in);
		`CHK(tx_active, 1'b0, "pin low stops")
		$display("test prbs done");
	endtask : t_prbs
	task automatic t_tones;
		logic signed [3:0] exp_ofs [4];
		exp_ofs = '{OFS_M2P0, OFS_P0P5, OFS_M0P5, OFS_M2P0};
		apb(1'b1, ADDR_FRAME_LEN, 32'h1);
		apb(1'b1, ADDR_FRAME_DATA, 32'h5a);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_STATE_CMD, CMD_OFF);
			apb(1'b1, ADDR_TEST_CFG, {29'h0, i[1:0], 1'b1});
			pin <= 1'b1;
			apb(1'b1, ADDR_STATE_CMD, CMD_PLL_ON);
			apb(1'b1, ADDR_STATE_CMD, CMD_TX_START);
			apb(1'b1, ADDR_TEST_CFG, 32'h0);
			`CHK(tx_cw, 1'b1, "tone mode")
			`CHK(ofs, exp_ofs[i], "tone offset")
			pin <= 1'b0;
			repeat (8) @(posedge clk_in);
		end
		$display("test tones done");
	endtask : t_tones
	task automatic final_report;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		{srst_in, psel_in, penable_in, pwrite_in, pin, slow} = 6'h20;
		paddr_in = 8'h0; pwdata_in = 32'h0;
		repeat (8) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		t_reset;
		t_prbs;
		t_tones;
		final_report;
	end
	initial begin
		#100000;
		n_fail++;
		final_report;
	end
endmodule : continuous_tx_test_mode_test
`default_nettype wire
